// File: logic/bea_defs.vh
// Constants for the bus exception and arbitration block
// Notes on behaviour
// RULE1 - Exception code: three active-low inputs, seven codes
// RULE2 - Nonzero code ends cycle, holds until zero
// RULE3 - Early exception immediate; late adds one clock
// RULE4 - Code zero: acknowledge ends cycle normally
// RULE5 - Halt: finish at acknowledge, release, resume later
// RULE6 - Bus error aborts cycle, releases bus
// RULE7 - After bus error, rearbitrate and report fault
// RULE8 - Retry keeps acknowledge, reruns same cycle
// RULE9 - Relinquish: release, debounce, rearbitrate, rerun
// RULE10 - Reset code runs internal reset sequence
// RULE11 - Reserved codes: no action, end at acknowledge
// RULE12 - Request bus for command or FIFO threshold
// RULE13 - Arbiter grants soon after request
// RULE14 - Wait strobe and acknowledge idle before acknowledging
// RULE15 - Drop request once acknowledge asserted
// RULE16 - Release bus only by dropping acknowledge
// RULE17 - Inputs synchronised within one clock; code uses two flops, so two clocks
// RULE18 - Command byte ff invokes software reset
// RULE19 - Hardware reset code held ten clocks
// RULE20 - Ready for command four clocks after reset
// RULE21 - Acknowledge two to three clocks after strobe
// RULE22 - Drop acknowledge one clock after last cycle
// RULE23 - Only command, vector, data registers writable
// RULE24 - Eight-bit bus register select by address
// RULE25 - Sixteen-bit bus register select with strobes
`ifndef BEA_DEFS_VH
`define BEA_DEFS_VH
`define BEA_EXC_NONE 3'h0
`define BEA_EXC_HALT 3'h1
`define BEA_EXC_BERR 3'h2
`define BEA_EXC_RETRY 3'h3
`define BEA_EXC_RELQ 3'h4
`define BEA_EXC_RES5 3'h5
`define BEA_EXC_RES6 3'h6
`define BEA_EXC_RESET 3'h7
`define BEA_SEL_CMD 2'h0
`define BEA_SEL_VEC 2'h1
`define BEA_SEL_DHI 2'h2
`define BEA_SEL_DLO 2'h3
`define BEA_CMD_RESET 8'hff
`define BEA_RESET_CYC 3'h4
`define BEA_DEBOUNCE_CYC 2'h2
`define BEA_FIFO_THRESH 6'h04
`define BEA_VEC_RESET 8'h00
`endif

// File: logic/bea_arbiter.v
// Bus exception decode, bus arbitration and host register writes
`timescale 1ns/1ns
`default_nettype none
`include "bea_defs.vh"
module bea_arbiter (
   input wire clock_in, // 20 MHz system clock
   input wire rst_in, // Synchronous reset, active high
   input wire [2:0] bus_exception_code_n_in, // Exception code, active low
   input wire dma_cmd_in, // Command needs DMA
   input wire tx_mode_in, // Transmit direction
   input wire [5:0] fifo_empty_words_in, // Empty FIFO words
   input wire [5:0] fifo_full_words_in, // Filled FIFO words
   input wire cycle_start_in, // Cycle engine starts a cycle
   input wire cycle_last_in, // Cycle in progress is the last one
   input wire [31:0] cycle_addr_in, // Address of the cycle
   input wire bg_n_in, // Bus grant, active low
   input wire bgack_n_in, // Grant ack seen on bus, active low
   input wire as_n_in, // Address strobe on bus, active low
   input wire dtack_n_in, // Transfer acknowledge, active low
   input wire cs_n_in, // Chip select, active low
   input wire rw_in, // High read, low write
   input wire [2:1] host_addr_in, // Host address bits 2..1
   input wire uds_a0_n_in, // Upper strobe or address bit 0
   input wire lds_ds_n_in, // Lower strobe or data strobe
   input wire bus16_in, // High selects 16-bit host bus
   input wire [15:0] host_data_in, // Host write data
   output reg br_n_out, // Bus request, active low
   output reg bgack_n_out, // Grant ack drive, active low
   output reg bgack_oe_out, // Grant ack output enable
   output reg cycle_end_out, // Current cycle terminated
   output reg cycle_rerun_out, // Rerun last cycle pulse
   output reg cycle_hold_out, // No new cycles allowed
   output reg bus_owned_out, // Device is bus master
   output reg berr_report_out, // Report bus error pulse
   output reg [31:0] berr_addr_out, // Failing address
   output reg soft_reset_out, // Internal reset sequence active
   output reg cmd_ready_out, // Ready for next command
   output reg [7:0] command_input_out, // Command register
   output reg cmd_strobe_out, // Command written pulse
   output reg [7:0] interrupt_vector_number_out, // Vector register
   output reg [31:0] command_parameter_data_out // Data register
);
   // ---------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------
   // Synchronised copies, active high
   reg [2:0] exc_s1_ff, exc_ff;
   reg bg_s1_ff, bg_ff, bgk_s1_ff, bgk_ff, as_s1_ff, as_ff, dt_s1_ff, dt_ff;
   // Two flops, first read only by second
   always @(posedge clock_in) begin
      exc_s1_ff <= ~bus_exception_code_n_in; // [RULE1] [RULE17]
      exc_ff <= exc_s1_ff;
      bg_s1_ff <= ~bg_n_in;
      bg_ff <= bg_s1_ff;
      bgk_s1_ff <= ~bgack_n_in;
      bgk_ff <= bgk_s1_ff;
      as_s1_ff <= ~as_n_in;
      as_ff <= as_s1_ff;
      dt_s1_ff <= ~dtack_n_in;
      dt_ff <= dt_s1_ff;
   end
   // ---------------------------------------------------
   // Arbitration state machine
   // ---------------------------------------------------
   // One-hot states
   localparam ST_IDLE = 8'h01;
   localparam ST_REQ = 8'h02;
   localparam ST_TAKE = 8'h04;
   localparam ST_CYC = 8'h08;
   localparam ST_DELAY = 8'h10;
   localparam ST_WAIT = 8'h20;
   localparam ST_RELEASE = 8'h40;
   localparam ST_DEBOUNCE = 8'h80;
   // Arbitration and exception state
   reg [7:0] state_ff, nxt_state;
   reg [2:0] act_ff, nxt_act; // Exception being served
   reg rerun_ff, nxt_rerun; // Pending rerun after release
   reg berr_pend_ff, nxt_berr_pend;
   reg dt_prev_ff; // Acknowledge seen last clock
   reg [1:0] deb_ff, nxt_deb;
   reg [2:0] rst_cnt_ff;
   reg nxt_end, nxt_rr, nxt_rep, nxt_own;
   // Bus demand from a command or the FIFO level
   wire need_bus = dma_cmd_in | (tx_mode_in ? (fifo_empty_words_in >= `BEA_FIFO_THRESH)
      : (fifo_full_words_in >= `BEA_FIFO_THRESH)); // [RULE12]
   // Exception classes seen on the synchronised code
   wire exc_act = (exc_ff == `BEA_EXC_HALT) | (exc_ff == `BEA_EXC_BERR) |
      (exc_ff == `BEA_EXC_RETRY) | (exc_ff == `BEA_EXC_RELQ);
   wire exc_res = (exc_ff == `BEA_EXC_RES5) | (exc_ff == `BEA_EXC_RES6);
   // Halt never cuts a cycle short, it waits for acknowledge
   wire exc_abort = exc_act & (exc_ff != `BEA_EXC_HALT); // [RULE5]
   wire hw_reset = (exc_ff == `BEA_EXC_RESET); // [RULE10]
   // First clock of an acknowledge, so a held one ends the cycle once
   wire dt_new = dt_ff & ~dt_prev_ff; // [RULE4]
   // Next state and cycle control
   always @* begin
      nxt_state = state_ff;
      nxt_act = act_ff;
      nxt_rerun = rerun_ff;
      nxt_berr_pend = berr_pend_ff;
      nxt_deb = deb_ff;
      nxt_end = 1'b0;
      nxt_rr = 1'b0;
      nxt_rep = 1'b0;
      nxt_own = bus_owned_out;
      case (state_ff)
         ST_IDLE: begin
            if (exc_ff == `BEA_EXC_NONE && (need_bus || rerun_ff || berr_pend_ff)) begin
               nxt_state = ST_REQ;
            end
         end
         ST_REQ: begin
            if (bg_ff) begin
               nxt_state = ST_TAKE; // [RULE13]
            end
         end
         ST_TAKE: begin
            if (!as_ff && !bgk_ff) begin
               nxt_state = ST_CYC; // [RULE14] [RULE21]
               nxt_own = 1'b1;
               if (rerun_ff) begin
                  nxt_rr = 1'b1;
                  nxt_rerun = 1'b0;
               end
               if (berr_pend_ff) begin
                  nxt_rep = 1'b1; // [RULE7]
                  nxt_berr_pend = 1'b0;
               end
            end
         end
         ST_CYC: begin
            if (exc_abort && !dt_ff && !dt_prev_ff) begin
               nxt_act = exc_ff; // [RULE3] early: end now
               nxt_end = 1'b1;
               nxt_state = ST_WAIT; // [RULE2]
            end else if (dt_ff || dt_prev_ff) begin
               if (exc_act || exc_res) begin
                  nxt_act = exc_ff; // [RULE3] [RULE11] late: one clock more
                  nxt_state = ST_DELAY;
               end else if (dt_new) begin
                  nxt_end = 1'b1; // [RULE4]
                  if (cycle_last_in) begin
                     nxt_state = ST_RELEASE; // [RULE22]
                  end
               end
            end
         end
         ST_DELAY: begin
            nxt_end = 1'b1;
            nxt_state = ST_WAIT;
            if (act_ff == `BEA_EXC_BERR || act_ff == `BEA_EXC_RELQ || act_ff == `BEA_EXC_HALT) begin
               nxt_own = 1'b0; // [RULE5] [RULE16]
            end
         end
         ST_WAIT: begin
            if (act_ff == `BEA_EXC_BERR || act_ff == `BEA_EXC_RELQ || act_ff == `BEA_EXC_HALT) begin
               nxt_own = 1'b0; // [RULE6] [RULE9]
            end
            if (exc_ff == `BEA_EXC_NONE) begin
               case (act_ff)
                  `BEA_EXC_RETRY: begin
                     nxt_rr = 1'b1; // [RULE8] keep ownership
                     nxt_state = ST_CYC;
                  end
                  `BEA_EXC_RELQ: begin
                     nxt_rerun = 1'b1;
                     nxt_deb = `BEA_DEBOUNCE_CYC;
                     nxt_state = ST_DEBOUNCE;
                  end
                  `BEA_EXC_BERR: begin
                     nxt_berr_pend = 1'b1;
                     nxt_state = ST_IDLE;
                  end
                  default: begin
                     nxt_state = bus_owned_out ? ST_CYC : ST_IDLE; // [RULE5] [RULE11]
                  end
               endcase
               nxt_act = `BEA_EXC_NONE;
            end
         end
         ST_RELEASE: begin
            nxt_own = 1'b0;
            nxt_state = ST_IDLE;
         end
         ST_DEBOUNCE: begin
            if (deb_ff == 2'h0) begin
               nxt_state = ST_IDLE; // [RULE9]
            end else begin
               nxt_deb = deb_ff - 2'h1;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end
   // ---------------------------------------------------
   // Registered state and outputs
   // ---------------------------------------------------
   // Reset from the pin, the exception code or the reset command
   wire any_reset = rst_in | hw_reset | (cmd_strobe_out &&
      command_input_out == `BEA_CMD_RESET); // [RULE10] [RULE18]
   always @(posedge clock_in) begin
      if (any_reset) begin
         state_ff <= ST_IDLE;
         act_ff <= `BEA_EXC_NONE;
         rerun_ff <= 1'b0;
         berr_pend_ff <= 1'b0;
         deb_ff <= 2'h0;
         dt_prev_ff <= 1'b0;
         br_n_out <= 1'b1;
         bgack_n_out <= 1'b1;
         bgack_oe_out <= 1'b0;
         cycle_end_out <= 1'b0;
         cycle_rerun_out <= 1'b0;
         cycle_hold_out <= 1'b0;
         bus_owned_out <= 1'b0;
         berr_report_out <= 1'b0;
         rst_cnt_ff <= `BEA_RESET_CYC; // [RULE20]
         soft_reset_out <= 1'b1;
         cmd_ready_out <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         act_ff <= nxt_act;
         rerun_ff <= nxt_rerun;
         berr_pend_ff <= nxt_berr_pend;
         deb_ff <= nxt_deb;
         dt_prev_ff <= (state_ff == ST_CYC) & dt_ff;
         br_n_out <= ~(nxt_state == ST_REQ || nxt_state == ST_TAKE); // [RULE15]
         bgack_n_out <= ~nxt_own; // [RULE16]
         bgack_oe_out <= nxt_own;
         cycle_end_out <= nxt_end;
         cycle_rerun_out <= nxt_rr;
         cycle_hold_out <= (nxt_state == ST_WAIT) | (nxt_state == ST_DELAY); // [RULE2]
         bus_owned_out <= nxt_own;
         berr_report_out <= nxt_rep;
         // Count out the reset sequence, then flag ready
         if (rst_cnt_ff != 3'h0) begin
            rst_cnt_ff <= rst_cnt_ff - 3'h1;
         end
         soft_reset_out <= (rst_cnt_ff > 3'h1);
         cmd_ready_out <= (rst_cnt_ff <= 3'h1);
      end
   end
   // Capture failing address at start of each cycle
   always @(posedge clock_in) begin
      if (rst_in) begin
         berr_addr_out <= 32'h0000_0000;
      end else if (state_ff == ST_CYC && cycle_start_in) begin
         berr_addr_out <= cycle_addr_in; // [RULE7]
      end
   end
   // ---------------------------------------------------
   // Host register writes
   // ---------------------------------------------------
   // Write taken on the first clock of the strobe only
   reg wr_prev_ff;
   wire wr_now = ~cs_n_in & ~rw_in & (~lds_ds_n_in | (bus16_in & ~uds_a0_n_in)); // [RULE23]
   wire wr_go = wr_now & ~wr_prev_ff;
   // Address and byte lane decode into the registers
   always @(posedge clock_in) begin
      if (rst_in) begin
         wr_prev_ff <= 1'b0;
         cmd_strobe_out <= 1'b0;
         command_input_out <= 8'h00;
         interrupt_vector_number_out <= `BEA_VEC_RESET;
         command_parameter_data_out <= 32'h0000_0000;
      end else begin
         wr_prev_ff <= wr_now;
         cmd_strobe_out <= 1'b0;
         if (wr_go) begin
            case (host_addr_in)
               `BEA_SEL_CMD: begin
                  command_input_out <= host_data_in[7:0];
                  cmd_strobe_out <= 1'b1;
               end
               `BEA_SEL_VEC: begin
                  interrupt_vector_number_out <= host_data_in[7:0];
               end
               default: begin
                  if (!bus16_in) begin
                     // Byte lanes from A1 and A0 [RULE24]
                     case ({host_addr_in[1], uds_a0_n_in})
                        2'h0: command_parameter_data_out[31:24] <= host_data_in[7:0];
                        2'h1: command_parameter_data_out[23:16] <= host_data_in[7:0];
                        2'h2: command_parameter_data_out[15:8] <= host_data_in[7:0];
                        default: command_parameter_data_out[7:0] <= host_data_in[7:0];
                     endcase
                  end else if (host_addr_in == `BEA_SEL_DHI) begin
                     // Upper strobe high byte, lower strobe low byte [RULE25]
                     if (!uds_a0_n_in) command_parameter_data_out[31:24] <= host_data_in[15:8];
                     if (!lds_ds_n_in) command_parameter_data_out[23:16] <= host_data_in[7:0];
                  end else begin
                     if (!uds_a0_n_in) command_parameter_data_out[15:8] <= host_data_in[15:8];
                     if (!lds_ds_n_in) command_parameter_data_out[7:0] <= host_data_in[7:0];
                  end
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench/bea_arbiter_asserts.sv
// Checker for the bus exception and arbitration block
`timescale 1ns/1ns
`default_nettype none
module bea_arbiter_asserts (
   input wire logic clock_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic [2:0] bus_exception_code_n_in, // Code, active low
   input wire logic as_n_in, // Bus strobe
   input wire logic br_n_out, // Request
   input wire logic bgack_n_out, // Grant ack
   input wire logic bgack_oe_out, // Grant ack enable
   input wire logic cycle_end_out, // End pulse
   input wire logic cycle_rerun_out, // Rerun pulse
   input wire logic bus_owned_out, // Mastership
   input wire logic soft_reset_out, // Reset sequence
   input wire logic cmd_ready_out, // Ready
   input wire logic [7:0] command_input_out, // Command
   input wire logic cmd_strobe_out // Command written
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   sequence s_prev_busy;
      (!as_n_in) [*4];
   endsequence
   sequence s_ready_late;
      !cmd_ready_out [*2] ##[1:4] cmd_ready_out;
   endsequence
   property p_own_drive;
      bus_owned_out |-> bgack_oe_out && !bgack_n_out;
   endproperty
   a_own_drive: assert property (p_own_drive) else $error("owner not driving");
   property p_drop_request;
      $fell(bgack_n_out) |-> br_n_out;
   endproperty
   a_drop_request: assert property (p_drop_request) else $error("request kept");
   property p_wait_idle;
      s_prev_busy |-> !$rose(bus_owned_out);
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("took busy bus");
   property p_no_request;
      (bus_exception_code_n_in != 3'h7) [*4] |-> !$fell(br_n_out);
   endproperty
   a_no_request: assert property (p_no_request) else $error("request in exception");
   property p_ready;
      $fell(rst_in) |-> s_ready_late;
   endproperty
   a_ready: assert property (p_ready) else $error("ready timing wrong");
   property p_soft_reset;
      cmd_strobe_out && command_input_out == 8'hff |-> ##[0:2] soft_reset_out;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("no soft reset");
   property p_release;
      $rose(bgack_n_out) && !soft_reset_out && !$past(soft_reset_out)
         |-> cycle_end_out || $past(cycle_end_out);
   endproperty
   a_release: assert property (p_release) else $error("release timing wrong");
   property p_rerun_owned;
      cycle_rerun_out |-> ##[0:1] bus_owned_out;
   endproperty
   a_rerun_owned: assert property (p_rerun_owned) else $error("rerun off bus");
endmodule
bind bea_arbiter bea_arbiter_asserts i_chk (.*);
`default_nettype wire

// File: testbench/bea_bus_model.sv
// Arbiter and prior bus master facing the block
`timescale 1ns/1ns
`default_nettype none
module bea_bus_model (
   input wire logic clock_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic br_n_in, // Request from block
   input wire logic bgack_n_in, // Grant ack drive of block
   input wire logic bgack_oe_in, // Grant ack enable of block
   input wire logic slow_in, // Hold off grant
   input wire logic prev_busy_in, // Prior master mid-cycle
   output logic bg_n_out, // Bus grant
   output logic bgack_bus_n_out, // Grant ack wire
   output logic as_n_out // Prior master strobe
);
   // Grant one clock after request unless held off
   always @(posedge clock_in) begin
      if (rst_in) begin
         bg_n_out <= 1'b1;
      end else begin
         bg_n_out <= br_n_in | slow_in;
      end
   end
   // Pulled-up wire reads high when released
   assign bgack_bus_n_out = bgack_oe_in ? bgack_n_in : 1'b1;
   assign as_n_out = !prev_busy_in;
endmodule
`default_nettype wire

// File: testbench/bea_arbiter_bench.sv
// Self-checking bench for the bus exception and arbitration block
`timescale 1ns/1ns
`default_nettype none
module bea_arbiter_bench;
   // -------
   // Signals
   // -------
   typedef struct packed {logic b; logic [1:0] a; logic u; logic l;
      logic [15:0] d; logic [31:0] e;} bea_row_t;
   logic clock_in = 0, rst_in = 1, dma_cmd_in = 0, tx_mode_in = 0, cycle_start_in = 0;
   logic cycle_last_in = 0, dtack_n_in = 1, cs_n_in = 1, rw_in = 1, uds_a0_n_in = 1;
   logic lds_ds_n_in = 1, bus16_in = 0, slow = 1, busy = 0;
   logic [2:0] bus_exception_code_n_in = 3'h7;
   logic [5:0] fifo_empty_words_in = 6'h00, fifo_full_words_in = 6'h00;
   logic [2:1] host_addr_in = 2'h0;
   logic [15:0] host_data_in = 16'h0000;
   logic [31:0] cycle_addr_in = 32'h00000000;
   logic [7:0] keep_map = 8'h69;
   wire bg_n_in, bgack_n_in, as_n_in, br_n_out, bgack_n_out, bgack_oe_out, cycle_end_out;
   wire cycle_rerun_out, cycle_hold_out, bus_owned_out, berr_report_out, soft_reset_out;
   wire cmd_ready_out, cmd_strobe_out;
   wire [7:0] command_input_out, interrupt_vector_number_out;
   wire [31:0] berr_addr_out, command_parameter_data_out;
   int bad_count = 0, n_compared = 0, reruns = 0, berrs = 0, resets = 0, strobes = 0;
   bea_row_t rows [10] = '{'{0, 0, 1, 0, 16'h00a5, 32'ha5}, '{0, 1, 0, 0, 16'h003c, 32'h3c},
      '{0, 2, 0, 0, 16'h0011, 32'h11000000}, '{0, 2, 1, 0, 16'h0022, 32'h11220000},
      '{0, 3, 0, 0, 16'h0033, 32'h11223300}, '{0, 3, 1, 0, 16'h0044, 32'h11223344},
      '{1, 2, 0, 1, 16'haabb, 32'haa223344}, '{1, 2, 1, 0, 16'hccdd, 32'haadd3344},
      '{1, 3, 0, 0, 16'heeff, 32'haaddeeff}, '{1, 0, 1, 0, 16'h0077, 32'h77}};
   bea_arbiter i_dut (.*);
   bea_bus_model i_model (.clock_in(clock_in), .rst_in(rst_in), .br_n_in(br_n_out),
      .bgack_n_in(bgack_n_out), .bgack_oe_in(bgack_oe_out), .slow_in(slow),
      .prev_busy_in(busy), .bg_n_out(bg_n_in), .bgack_bus_n_out(bgack_n_in), .as_n_out(as_n_in));
   // -----
   // Tasks
   // -----
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic look();
      @(negedge clock_in);
   endtask
   task automatic wr(input logic b, input logic [1:0] a, input logic u, input logic l,
         input logic [15:0] d, input logic r);
      bus16_in <= b;
      host_addr_in <= a;
      uds_a0_n_in <= u;
      lds_ds_n_in <= l;
      host_data_in <= d;
      rw_in <= r;
      cs_n_in <= 1'b0;
      tick(3);
      cs_n_in <= 1'b1;
      uds_a0_n_in <= 1'b1;
      lds_ds_n_in <= 1'b1;
      tick(2);
   endtask
   task automatic cyc(input logic [2:0] c, input logic dt, output int n);
      cycle_addr_in <= 32'h1000 + c;
      cycle_start_in <= 1'b1;
      tick(1);
      cycle_start_in <= 1'b0;
      bus_exception_code_n_in <= ~c;
      dtack_n_in <= !dt;
      for (n = 0; n < 20 && cycle_end_out !== 1'b1; n++) look();
      chk("cycle end", 1, cycle_end_out);
      tick(1);
      dtack_n_in <= 1'b1;
   endtask
   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ---------
   // Processes
   // ---------
   // Clock, pulse counters and watchdog
   initial forever #25 clock_in = ~clock_in;
   always @(negedge clock_in) begin
      reruns += (cycle_rerun_out === 1'b1);
      berrs += (berr_report_out === 1'b1);
      resets += (soft_reset_out === 1'b1);
      strobes += (cmd_strobe_out === 1'b1);
   end
   initial begin
      tick(4000);
      bad_count++;
      end_of_test();
   end
   // Main sequence
   initial begin
      int n, n_norm, r0, b0;
      logic [31:0] got;
      tick(10);
      rst_in <= 1'b0;
      tick(1);
      wr(1, 3, 0, 0, 16'h0000, 0);
      wr(1, 2, 0, 0, 16'h0000, 0);
      foreach (rows[k]) begin
         wr(rows[k].b, rows[k].a, rows[k].u, rows[k].l, rows[k].d, 0);
         look();
         got = rows[k].a == 2'h0 ? {24'h0, command_input_out} : command_parameter_data_out;
         if (rows[k].a == 2'h1) got = {24'h0, interrupt_vector_number_out};
         chk("host register", rows[k].e, got);
         tick(1);
      end
      wr(0, 0, 1, 0, 16'h0099, 1);
      look();
      chk("command after read", 32'h77, {24'h0, command_input_out});
      chk("command strobes", 2, strobes);
      $display("host write test done");
      tick(1);
      busy <= 1'b1;
      dma_cmd_in <= 1'b1;
      for (n = 0; n < 20 && br_n_out !== 1'b0; n++) look();
      chk("bus request", 0, br_n_out);
      tick(4);
      slow <= 1'b0;
      tick(8);
      look();
      chk("owned while strobe busy", 0, bus_owned_out);
      tick(1);
      busy <= 1'b0;
      for (n = 0; n < 20 && bus_owned_out !== 1'b1; n++) look();
      chk("takeover window", 1, n >= 3 && n <= 5);
      chk("request after ack", 1, br_n_out);
      tick(1);
      for (int c = 0; c < 7; c++) begin
         r0 = reruns;
         b0 = berrs;
         cyc(c[2:0], 1, n);
         if (c == 0) n_norm = n;
         chk("end delay", n_norm + (c != 0), n);
         tick(3);
         look();
         chk("owned after end", keep_map[c], bus_owned_out);
         chk("cycles held", c != 0, cycle_hold_out);
         tick(1);
         bus_exception_code_n_in <= 3'h7;
         for (n = 0; n < 40 && (bus_owned_out !== 1'b1 || cycle_hold_out !== 1'b0); n++) look();
         tick(2);
         look();
         chk("owned again", 1, bus_owned_out);
         chk("reruns", c == 3 || c == 4, reruns - r0);
         chk("fault reports", c == 2, berrs - b0);
         if (c == 2) chk("fault address", 32'h1002, berr_addr_out);
         tick(1);
      end
      r0 = reruns;
      cyc(3'h3, 0, n);
      chk("early end", n_norm, n);
      bus_exception_code_n_in <= 3'h7;
      tick(8);
      chk("early rerun", 1, reruns - r0);
      dma_cmd_in <= 1'b0;
      cycle_last_in <= 1'b1;
      cyc(3'h0, 1, n);
      cycle_last_in <= 1'b0;
      tick(2);
      look();
      chk("released", 0, bus_owned_out);
      chk("grant ack idle", 1, bgack_n_out);
      chk("grant ack enable", 0, bgack_oe_out);
      $display("arbitration and exception tests done");
      tick(1);
      r0 = resets;
      bus_exception_code_n_in <= 3'h0;
      tick(10);
      bus_exception_code_n_in <= 3'h7;
      for (n = 0; n < 20 && cmd_ready_out !== 1'b1; n++) look();
      chk("reset by code", 1, resets > r0);
      chk("ready after reset", 1, n <= 10 && cmd_ready_out);
      tick(1);
      r0 = resets;
      wr(0, 0, 1, 0, 16'h00ff, 0);
      for (n = 0; n < 20 && cmd_ready_out !== 1'b1; n++) look();
      chk("reset by command", 1, resets > r0);
      chk("ready after command", 1, cmd_ready_out);
      tick(1);
      tx_mode_in <= 1'b1;
      fifo_empty_words_in <= 6'h03;
      fifo_full_words_in <= 6'h04;
      tick(8);
      look();
      chk("no request below four", 1, br_n_out);
      tick(1);
      fifo_empty_words_in <= 6'h04;
      for (n = 0; n < 20 && br_n_out !== 1'b0; n++) look();
      chk("request at four", 0, br_n_out);
      $display("reset and request tests done");
      end_of_test();
   end
endmodule
`default_nettype wire
